// ==== hdl/timer16_pkg.sv ====
`default_nettype none
package timer16_pkg;
	localparam int CNT_W = 16;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 6;

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNTER = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_A = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_B = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_CAPTURE = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h1C;

	// control a fields
	localparam int COM_A_LSB = 6;
	localparam int COM_B_LSB = 4;
	localparam int WMODE_LOW_LSB = 0;
	localparam logic [7:0] CONTROL_A_WMASK = 8'hF3;
	localparam logic [7:0] CONTROL_A_RESET = 8'h00;
	// control b fields
	localparam int WMODE_HIGH_LSB = 3;
	localparam int CLK_SEL_LSB = 0;
	localparam logic [7:0] CONTROL_B_WMASK = 8'h1F;
	localparam logic [7:0] CONTROL_B_RESET = 8'h00;

	// interrupt status / mask bits
	localparam int IRQ_OVF = 0;
	localparam int IRQ_MATCH_A = 1;
	localparam int IRQ_MATCH_B = 2;
	localparam int IRQ_W = 3;

	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] TOP_8BIT = 16'h00FF;
	localparam logic [CNT_W-1:0] TOP_9BIT = 16'h01FF;
	localparam logic [CNT_W-1:0] TOP_10BIT = 16'h03FF;

	// waveform mode codes
	localparam logic [3:0] WM_NORMAL = 4'h0;
	localparam logic [3:0] WM_PC8 = 4'h1;
	localparam logic [3:0] WM_PC9 = 4'h2;
	localparam logic [3:0] WM_PC10 = 4'h3;
	localparam logic [3:0] WM_CTC_CMP = 4'h4;
	localparam logic [3:0] WM_FAST8 = 4'h5;
	localparam logic [3:0] WM_FAST9 = 4'h6;
	localparam logic [3:0] WM_FAST10 = 4'h7;
	localparam logic [3:0] WM_PFC_CAP = 4'h8;
	localparam logic [3:0] WM_PFC_CMP = 4'h9;
	localparam logic [3:0] WM_PC_CAP = 4'hA;
	localparam logic [3:0] WM_PC_CMP = 4'hB;
	localparam logic [3:0] WM_CTC_CAP = 4'hC;
	localparam logic [3:0] WM_RESERVED = 4'hD;
	localparam logic [3:0] WM_FAST_CAP = 4'hE;
	localparam logic [3:0] WM_FAST_CMP = 4'hF;

	// clock source select codes and prescaler masks
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRE_W = 10;
	localparam logic [PRE_W-1:0] PRE_MASK_8 = 10'h007;
	localparam logic [PRE_W-1:0] PRE_MASK_64 = 10'h03F;
	localparam logic [PRE_W-1:0] PRE_MASK_256 = 10'h0FF;
	localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3FF;

	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	typedef enum logic [2:0] {
		CLS_SINGLE = 3'b001,
		CLS_FAST   = 3'b010,
		CLS_DUAL   = 3'b100
	} wave_class_t;
endpackage
`default_nettype wire

// ==== hdl/compare_out_unit.sv ====
`default_nettype none
module compare_out_unit (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire timer16_pkg::wave_class_t  wave_class,
	input  wire logic [1:0]                compare_out_mode,
	input  wire logic                      toggle_ok,
	input  wire logic                      match,
	input  wire logic                      wrap,
	input  wire logic                      counting_up,
	input  wire logic                      port_data,
	input  wire logic                      port_dir,
	output var  logic                      wave,
	output logic                           pin_out,
	output logic                           pin_oe,
	output logic                           connected
);
	import timer16_pkg::*;

	logic next_wave;
	wire  pwm = (wave_class != CLS_SINGLE);
	wire  m1 = compare_out_mode[1];

	assign connected = (compare_out_mode != COM_OFF) &&
		!(pwm && compare_out_mode == COM_TOGGLE && !toggle_ok);
	assign pin_out = connected ? wave : port_data;
	assign pin_oe = port_dir;

	always_comb begin
		next_wave = wave;
		case (wave_class)
			CLS_FAST: begin
				// wrap first: a compare value at TOP yields the bottom action
				if (m1 && wrap)
					next_wave = !compare_out_mode[0];
				else if (m1 && match)
					next_wave = compare_out_mode[0];
				else if (connected && match && !m1)
					next_wave = !wave;
			end
			CLS_DUAL: begin
				if (m1 && match)
					next_wave = compare_out_mode[0] ^ !counting_up;
				else if (connected && match && !m1)
					next_wave = !wave;
			end
			default: begin
				if (match) begin
					case (compare_out_mode)
						COM_TOGGLE: next_wave = !wave;
						COM_CLEAR: next_wave = 1'b0;
						COM_SET: next_wave = 1'b1;
						default: next_wave = wave;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			wave <= 1'b0;
		else
			wave <= next_wave;
	end

	chk_nonpwm_toggle: assert property (@(posedge clk) disable iff (sys_rst)
		wave_class == CLS_SINGLE && match && compare_out_mode == COM_TOGGLE
		|=> wave != $past(wave))
		else $error("toggle on match missing");
	chk_dual_slope: assert property (@(posedge clk) disable iff (sys_rst)
		wave_class == CLS_DUAL && match && m1
		|=> wave == ($past(compare_out_mode[0]) ^ !$past(counting_up)))
		else $error("dual slope action wrong");
	chk_fast_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		wave_class == CLS_FAST && wrap && m1
		|=> wave == !$past(compare_out_mode[0]))
		else $error("fast pwm bottom action wrong");
	chk_pin_driver: assert property (@(posedge clk) disable iff (sys_rst)
		pin_oe == port_dir && (connected || pin_out == port_data))
		else $error("pin driver not under direction bit");
endmodule
`default_nettype wire

// ==== hdl/timer16_waveform_mode_control.sv ====
// How it works
// - the counter and compares run on clk, the timer tick only enables them.
// - a nonzero compare-out field hands the pin to the wave; direction enables.
// - non-PWM codes: off, toggle, clear or set on a compare match.
// - fast PWM code 01 toggles output A only in modes 14/15, else disconnects.
// - fast PWM code 10 clears on match, sets at BOTTOM; code 11 the reverse.
// - fast PWM with compare equal to TOP takes the BOTTOM action, not the match.
// - dual-slope code 01 toggles output A only in modes 9/11, else off.
// - dual-slope code 10 clears up-counting and sets down-counting; 11 reverse.
// - the mode code joins control a bits 1:0 with control b high bits.
// - the mode picks sequence, TOP and waveform; mode 13 is reserved.
// - modes 0, 4, 12 use TOP 0xFFFF/compare A/capture, immediate, flag at MAX.
// - modes 1-3, 10, 11 are phase correct, load at TOP, flag at BOTTOM.
// - modes 5-7, 14, 15 are fast PWM, load and flag at TOP.
// - modes 8, 9 take TOP from capture or compare A, load and flag at BOTTOM.
// - clock select stops, divides by 1/8/64/256/1024, or uses the pin edges.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`default_nettype none
module timer16_waveform_mode_control (
	input  wire logic                            clk,
	input  wire logic                            sys_rst,
	input  wire logic [timer16_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                            avs_read,
	input  wire logic                            avs_write,
	input  wire logic [timer16_pkg::DATA_W-1:0]  avs_writedata,
	input  wire logic [3:0]                      avs_byteenable,
	output var  logic [timer16_pkg::DATA_W-1:0]  avs_readdata,
	output logic                                 avs_waitrequest,
	input  wire logic                            external_count_pin,
	input  wire logic                            port_data_a,
	input  wire logic                            port_dir_a,
	input  wire logic                            port_data_b,
	input  wire logic                            port_dir_b,
	output logic                                 wave_out_a,
	output logic                                 wave_out_a_oe,
	output logic                                 wave_out_b,
	output logic                                 wave_out_b_oe,
	output logic                                 irq
);
	import timer16_pkg::*;

	logic [7:0]       timer16_control_a;
	logic [7:0]       timer16_control_b;
	logic [CNT_W-1:0] counter_value;
	logic [CNT_W-1:0] compare_buf_a;
	logic [CNT_W-1:0] compare_buf_b;
	logic [CNT_W-1:0] compare_value_a;
	logic [CNT_W-1:0] compare_value_b;
	logic [CNT_W-1:0] capture_value;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic             counting_up;
	logic             block_match;
	logic             ack;
	logic [PRE_W-1:0] prescale;
	logic             ext_s1;
	logic             ext_s2;
	logic             ext_s3;
	logic [CNT_W-1:0] next_counter;
	logic             next_up;
	logic [CNT_W-1:0] top_value;
	logic [DATA_W-1:0] next_readdata;
	logic             timer_tick;
	wave_class_t      wave_class;

	// bus decode: one wait state, then the access completes
	wire req = avs_read | avs_write;
	wire wr_en = avs_write & ack;
	wire sel_ctrl_a = (avs_address == OFS_CONTROL_A);
	wire sel_ctrl_b = (avs_address == OFS_CONTROL_B);
	wire sel_count = (avs_address == OFS_COUNTER);
	wire sel_cmp_a = (avs_address == OFS_COMPARE_A);
	wire sel_cmp_b = (avs_address == OFS_COMPARE_B);
	wire sel_capt = (avs_address == OFS_CAPTURE);
	wire sel_status = (avs_address == OFS_IRQ_STATUS);
	wire sel_mask = (avs_address == OFS_IRQ_MASK);
	wire lane0 = wr_en & avs_byteenable[0];
	wire [1:0] lanes16 = {2{wr_en}} & avs_byteenable[1:0];
	wire cnt_wr = sel_count & (|lanes16);

	assign avs_waitrequest = req & ~ack;

	function automatic logic [CNT_W-1:0] merge16(
		input logic [CNT_W-1:0] old,
		input logic [DATA_W-1:0] wd,
		input logic [1:0] be
	);
		merge16 = {be[1] ? wd[15:8] : old[15:8],
			be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// mode code and its decoded properties
	wire [1:0] compare_out_mode_a = timer16_control_a[COM_A_LSB +: 2];
	wire [1:0] compare_out_mode_b = timer16_control_a[COM_B_LSB +: 2];
	wire [1:0] waveform_mode_low = timer16_control_a[WMODE_LOW_LSB +: 2];
	wire [1:0] waveform_mode_high = timer16_control_b[WMODE_HIGH_LSB +: 2];
	wire [2:0] clock_source_sel = timer16_control_b[CLK_SEL_LSB +: 3];
	wire [3:0] waveform_mode_code = {waveform_mode_high,
		waveform_mode_low};
	wire m = 1'b0;
	wire is_pc = (waveform_mode_code == WM_PC8) ||
		(waveform_mode_code == WM_PC9) ||
		(waveform_mode_code == WM_PC10) ||
		(waveform_mode_code == WM_PC_CAP) ||
		(waveform_mode_code == WM_PC_CMP);
	wire is_pfc = (waveform_mode_code == WM_PFC_CAP) ||
		(waveform_mode_code == WM_PFC_CMP);
	wire is_fast = (waveform_mode_code == WM_FAST8) ||
		(waveform_mode_code == WM_FAST9) ||
		(waveform_mode_code == WM_FAST10) ||
		(waveform_mode_code == WM_FAST_CAP) ||
		(waveform_mode_code == WM_FAST_CMP);
	wire is_resv = (waveform_mode_code == WM_RESERVED);
	wire is_dual = is_pc | is_pfc;
	wire toggle_ok_a = (is_fast && (waveform_mode_code == WM_FAST_CAP ||
		waveform_mode_code == WM_FAST_CMP)) ||
		(is_dual && (waveform_mode_code == WM_PFC_CMP ||
		waveform_mode_code == WM_PC_CMP));

	always_comb begin
		if (is_fast)
			wave_class = CLS_FAST;
		else if (is_dual)
			wave_class = CLS_DUAL;
		else
			wave_class = CLS_SINGLE;
	end

	always_comb begin
		case (waveform_mode_code)
			WM_PC8, WM_FAST8: top_value = TOP_8BIT;
			WM_PC9, WM_FAST9: top_value = TOP_9BIT;
			WM_PC10, WM_FAST10: top_value = TOP_10BIT;
			WM_CTC_CMP, WM_PFC_CMP, WM_PC_CMP, WM_FAST_CMP:
				top_value = compare_value_a;
			WM_PFC_CAP, WM_PC_CAP, WM_CTC_CAP, WM_FAST_CAP:
				top_value = capture_value;
			default: top_value = CNT_MAX;
		endcase
	end

	// clock source: prescaled tick is a clock enable, not a clock
	wire ext_fall = ext_s3 & ~ext_s2;
	wire ext_rise = ~ext_s3 & ext_s2;
	always_comb begin
		case (clock_source_sel)
			CS_DIV1: timer_tick = 1'b1;
			CS_DIV8: timer_tick = (prescale & PRE_MASK_8) == PRE_MASK_8;
			CS_DIV64: timer_tick = (prescale & PRE_MASK_64) == PRE_MASK_64;
			CS_DIV256: timer_tick = (prescale & PRE_MASK_256) == PRE_MASK_256;
			CS_DIV1024: timer_tick = prescale == PRE_MASK_1024;
			CS_EXT_FALL: timer_tick = ext_fall;
			CS_EXT_RISE: timer_tick = ext_rise;
			default: timer_tick = 1'b0;
		endcase
	end

	wire at_top = (counter_value == top_value);
	wire at_bottom = (counter_value == CNT_RESET);
	wire run = timer_tick & ~is_resv & ~cnt_wr;
	// a software write to the counter hides the next tick's matches
	wire match_a = run & ~block_match & (counter_value == compare_value_a);
	wire match_b = run & ~block_match & (counter_value == compare_value_b);
	wire wrap = run & is_fast & at_top;
	wire ovf_evt = run & (is_dual ? at_bottom :
		(is_fast ? at_top : (counter_value == CNT_MAX)));
	wire load_evt = run & ((is_pc & at_top) |
		(is_pfc & at_bottom) | (is_fast & at_top));
	wire immediate = ~is_dual & ~is_fast;

	always_comb begin
		next_counter = counter_value;
		next_up = counting_up;
		if (cnt_wr) begin
			next_counter = merge16(counter_value, avs_writedata, lanes16);
		end else if (run) begin
			if (is_dual) begin
				if (counting_up && at_top) begin
					next_up = 1'b0;
					next_counter = counter_value - 16'h0001;
				end else if (!counting_up && at_bottom) begin
					next_up = 1'b1;
					next_counter = counter_value + 16'h0001;
				end else if (counting_up) begin
					next_counter = counter_value + 16'h0001;
				end else begin
					next_counter = counter_value - 16'h0001;
				end
			end else if (at_top) begin
				next_counter = CNT_RESET;
			end else begin
				next_counter = counter_value + 16'h0001;
			end
		end
	end

	always_comb begin
		next_readdata = '0;
		if (sel_ctrl_a)
			next_readdata[7:0] = timer16_control_a;
		else if (sel_ctrl_b)
			next_readdata[7:0] = timer16_control_b;
		else if (sel_count)
			next_readdata[CNT_W-1:0] = counter_value;
		else if (sel_cmp_a)
			next_readdata[CNT_W-1:0] = compare_buf_a;
		else if (sel_cmp_b)
			next_readdata[CNT_W-1:0] = compare_buf_b;
		else if (sel_capt)
			next_readdata[CNT_W-1:0] = capture_value;
		else if (sel_status)
			next_readdata[IRQ_W-1:0] = irq_status;
		else if (sel_mask)
			next_readdata[IRQ_W-1:0] = irq_mask;
	end

	wire [IRQ_W-1:0] irq_set = {match_b, match_a, ovf_evt};
	wire [IRQ_W-1:0] irq_clr = (sel_status & lane0) ?
		avs_writedata[IRQ_W-1:0] : '0;
	assign irq = |(irq_status & irq_mask);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack <= 1'b0;
			avs_readdata <= '0;
		end else begin
			ack <= req & ~ack;
			if (req & ~ack)
				avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer16_control_a <= CONTROL_A_RESET;
			timer16_control_b <= CONTROL_B_RESET;
			irq_mask <= '0;
			irq_status <= '0;
			capture_value <= CNT_RESET;
			compare_buf_a <= CNT_RESET;
			compare_buf_b <= CNT_RESET;
		end else begin
			if (sel_ctrl_a & lane0)
				timer16_control_a <= avs_writedata[7:0] &
					CONTROL_A_WMASK;
			if (sel_ctrl_b & lane0)
				timer16_control_b <= avs_writedata[7:0] & CONTROL_B_WMASK;
			if (sel_mask & lane0)
				irq_mask <= avs_writedata[IRQ_W-1:0];
			// set wins over a clear in the same cycle
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			if (sel_capt)
				capture_value <= merge16(capture_value, avs_writedata,
					lanes16);
			if (sel_cmp_a)
				compare_buf_a <= merge16(compare_buf_a, avs_writedata,
					lanes16);
			if (sel_cmp_b)
				compare_buf_b <= merge16(compare_buf_b, avs_writedata,
					lanes16);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			compare_value_a <= CNT_RESET;
			compare_value_b <= CNT_RESET;
		end else if (immediate | load_evt) begin
			compare_value_a <= compare_buf_a;
			compare_value_b <= compare_buf_b;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			counter_value <= CNT_RESET;
			counting_up <= 1'b1;
			block_match <= 1'b0;
		end else begin
			counter_value <= next_counter;
			counting_up <= next_up;
			if (cnt_wr)
				block_match <= 1'b1;
			else if (timer_tick)
				block_match <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prescale <= '0;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			prescale <= prescale + 10'h001;
			ext_s1 <= external_count_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	compare_out_unit unit_a (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.wave_class       (wave_class),
		.compare_out_mode (compare_out_mode_a),
		.toggle_ok        (toggle_ok_a),
		.match            (match_a),
		.wrap             (wrap),
		.counting_up      (counting_up),
		.port_data        (port_data_a),
		.port_dir         (port_dir_a),
		.wave             (),
		.pin_out          (wave_out_a),
		.pin_oe           (wave_out_a_oe),
		.connected        ()
	);

	// output b never toggles in a PWM mode
	compare_out_unit unit_b (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.wave_class       (wave_class),
		.compare_out_mode (compare_out_mode_b),
		.toggle_ok        (m),
		.match            (match_b),
		.wrap             (wrap),
		.counting_up      (counting_up),
		.port_data        (port_data_b),
		.port_dir         (port_dir_b),
		.wave             (),
		.pin_out          (wave_out_b),
		.pin_oe           (wave_out_b_oe),
		.connected        ()
	);

	chk_stop_holds: assert property (@(posedge clk) disable iff (sys_rst)
		clock_source_sel == CS_STOP && !cnt_wr |=> $stable(counter_value))
		else $error("counter moved while stopped");
	chk_normal_step: assert property (@(posedge clk) disable iff (sys_rst)
		waveform_mode_code == WM_NORMAL && clock_source_sel == CS_DIV1 &&
		!cnt_wr |=> counter_value == $past(counter_value) + 16'h0001)
		else $error("normal mode did not step");
	chk_reserved_halt: assert property (@(posedge clk) disable iff (sys_rst)
		is_resv && !cnt_wr |=> $stable(counter_value))
		else $error("reserved mode counted");
	chk_pc8_turn: assert property (@(posedge clk) disable iff (sys_rst)
		waveform_mode_code == WM_PC8 && run && counting_up &&
		counter_value == TOP_8BIT |=> !counting_up)
		else $error("phase correct did not turn at top");
	chk_fast8_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		waveform_mode_code == WM_FAST8 && run && counter_value == TOP_8BIT
		|=> counter_value == CNT_RESET ##0 irq_status[IRQ_OVF])
		else $error("fast pwm wrap or flag wrong");
	chk_dual_ovf: assert property (@(posedge clk) disable iff (sys_rst)
		is_dual && run && at_bottom |=> irq_status[IRQ_OVF])
		else $error("bottom overflow flag missing");
	chk_pfc_hold: assert property (@(posedge clk) disable iff (sys_rst)
		is_pfc && !(run && at_bottom) |=> $stable(compare_value_a))
		else $error("compare loaded away from bottom");
	chk_immediate_load: assert property (@(posedge clk) disable iff (sys_rst)
		waveform_mode_code == WM_CTC_CAP |=>
		compare_value_a == $past(compare_buf_a))
		else $error("immediate compare update missing");
	chk_ctrl_a_unused: assert property (@(posedge clk) disable iff (sys_rst)
		timer16_control_a[3:2] == 2'b00)
		else $error("unused control bits set");
	chk_div8_tick: assert property (@(posedge clk) disable iff (sys_rst)
		clock_source_sel == CS_DIV8 && timer_tick
		|=> !timer_tick || clock_source_sel != CS_DIV8)
		else $error("divide by 8 ticked twice");
endmodule
`default_nettype wire

// ==== sim/timer16_waveform_mode_control_test.sv ====
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module timer16_waveform_mode_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	import timer16_pkg::*;
	logic              clk, sys_rst, avs_read, avs_write, irq;
	logic              port_data_a, port_dir_a, port_data_b, port_dir_b;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
	logic              avs_waitrequest, wave_out_a, wave_out_a_oe;
	logic              wave_out_b, wave_out_b_oe, ext_pin;
	int                n_fail = 0;
	int                checks = 0;

	timer16_waveform_mode_control dut (
		.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.external_count_pin(ext_pin), .port_data_a(port_data_a),
		.port_dir_a(port_dir_a), .port_data_b(port_data_b),
		.port_dir_b(port_dir_b), .wave_out_a(wave_out_a),
		.wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
		.wave_out_b_oe(wave_out_b_oe), .irq(irq)
	);

	always #25 clk = ~clk;

	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// one request; waits for the wait state to end, bounded
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		// waitrequest and read data are taken at the rising edge only
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			final_report();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic setmode(input logic [3:0] m, input logic [1:0] ca, cb);
		bus(1'b1, OFS_CONTROL_A, {24'h0, ca, cb, 2'h0, m[1:0]});
		bus(1'b1, OFS_CONTROL_B, {27'h0, m[3:2], CS_DIV1});
		// restart from bottom so short TOPs are never overrun
		bus(1'b1, OFS_COUNTER, 32'h0);
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		// let the edge that cleared the status settle before looking
		do begin
			@(negedge clk);
			n++;
		end while (irq !== 1'b1 && n < 200);
		if (irq !== 1'b1) begin
			n_fail++;
			final_report();
		end
	endtask

	task automatic regs_test();
		bus(1'b0, OFS_CONTROL_A, 32'h0);
		`CHK("ctrl_a_rst", 32'h00, q)
		bus(1'b1, OFS_CONTROL_A, 32'hFF);
		bus(1'b0, OFS_CONTROL_A, 32'h0);
		`CHK("ctrl_a_bits", 32'hF3, q)
		bus(1'b1, OFS_CONTROL_A, 32'h0);
		bus(1'b0, 6'h3C, 32'h0);
		`CHK("unmapped", 32'h0, q)
		port_data_a <= 1'b1;
		@(posedge clk);
		`CHK("port_a", 1'b1, wave_out_a)
		port_data_a <= 1'b0;
		setmode(WM_CTC_CAP, COM_OFF, COM_OFF);
		bus(1'b0, OFS_CONTROL_B, 32'h0);
		`CHK("ctrl_b", 32'h19, q)
	endtask

	task automatic compare_test();
		logic [1:0] code [3] = '{COM_SET, COM_CLEAR, COM_TOGGLE};
		logic       expv [3] = '{1'b1, 1'b0, 1'b1};
		bus(1'b1, OFS_COMPARE_A, 32'h10);
		bus(1'b1, OFS_IRQ_MASK, 32'h2);
		for (int i = 0; i < 3; i++) begin
			setmode(WM_NORMAL, code[i], COM_OFF);
			bus(1'b1, OFS_IRQ_STATUS, 32'h7);
			wait_irq();
			`CHK("wave_a", expv[i], wave_out_a)
			`CHK("oe_a", 1'b1, wave_out_a_oe)
			`CHK("oe_b", 1'b0, wave_out_b_oe)
		end
		bus(1'b0, OFS_IRQ_STATUS, 32'h0);
		`CHK("status", 1'b1, q[IRQ_MATCH_A])
		// masking hides a still-set status bit
		bus(1'b1, OFS_IRQ_MASK, 32'h0);
		@(negedge clk);
		`CHK("irq_masked", 1'b0, irq)
		bus(1'b1, OFS_IRQ_MASK, 32'h2);
		bus(1'b1, OFS_IRQ_STATUS, 32'h2);
		@(negedge clk);
		`CHK("irq_clear", 1'b0, irq)
	endtask

	task automatic gate_test();
		logic [3:0] md [6] = '{4'h1, 4'h5, 4'h9, 4'hB, 4'hE, 4'hF};
		logic       cn [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
		logic       prev;
		int         n, e;
		bus(1'b1, OFS_CAPTURE, 32'h20);
		for (int i = 0; i < 6; i++) begin
			setmode(md[i], COM_TOGGLE, COM_TOGGLE);
			n = 0;
			e = 0;
			prev = wave_out_a;
			repeat (120) begin
				@(negedge clk);
				if (wave_out_a !== prev) n++;
				prev = wave_out_a;
				if (wave_out_b !== 1'b1) e++;
			end
			`CHK("a_toggles", cn[i], n > 0)
			`CHK("b_port", 0, e)
		end
	endtask

	// high time over one whole period, allowing pipeline slack
	task automatic duty(input logic [3:0] m, input logic [1:0] c,
		input int per, input int ex);
		int n;
		bus(1'b1, OFS_COMPARE_A, 32'h40);
		setmode(m, c, COM_OFF);
		repeat (600) @(negedge clk);
		n = 0;
		repeat (per) begin
			@(negedge clk);
			if (wave_out_a === 1'b1) n++;
		end
		`CHK("duty", 1'b1, n >= ex - 2 && n <= ex + 2)
	endtask

	// counter position 1101 steps after a restart from zero shows the TOP
	task automatic top_test();
		logic [3:0]  md [8] = '{4'h2, 4'h3, 4'h6, 4'h7,
			4'h8, 4'hA, 4'h4, 4'hC};
		logic [15:0] ev [8] = '{16'h004F, 16'h03B1, 16'h004D, 16'h004D,
			16'h000D, 16'h000D, 16'h003D, 16'h000C};
		for (int i = 0; i < 8; i++) begin
			setmode(md[i], COM_OFF, COM_OFF);
			repeat (1100) @(posedge clk);
			bus(1'b0, OFS_COUNTER, 32'h0);
			`CHK("top_count", ev[i], q[15:0])
		end
	endtask

	task automatic ext_pulses(input int k);
		repeat (k) begin
			ext_pin <= 1'b1;
			repeat (4) @(posedge clk);
			ext_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask

	// prescaled and pin ticks only enable the counter
	task automatic clock_test();
		setmode(WM_NORMAL, COM_OFF, COM_OFF);
		bus(1'b1, OFS_CONTROL_B, {29'h0, CS_DIV8});
		bus(1'b1, OFS_COUNTER, 32'h0);
		repeat (80) @(posedge clk);
		bus(1'b0, OFS_COUNTER, 32'h0);
		`CHK("div8", 1'b1, q >= 10 && q <= 11)
		bus(1'b1, OFS_CONTROL_B, {29'h0, CS_EXT_RISE});
		bus(1'b1, OFS_COUNTER, 32'h0);
		ext_pulses(5);
		bus(1'b0, OFS_COUNTER, 32'h0);
		`CHK("ext_rise", 32'h5, q)
		bus(1'b1, OFS_CONTROL_B, {29'h0, CS_EXT_FALL});
		bus(1'b1, OFS_COUNTER, 32'h0);
		ext_pulses(3);
		bus(1'b0, OFS_COUNTER, 32'h0);
		`CHK("ext_fall", 32'h3, q)
	endtask

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		port_data_a = 1'b0;
		port_dir_a = 1'b1;
		port_data_b = 1'b1;
		port_dir_b = 1'b0;
		ext_pin = 1'b0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		regs_test();
		compare_test();
		gate_test();
		duty(WM_FAST8, COM_CLEAR, 256, 64);
		duty(WM_FAST8, COM_SET, 256, 192);
		duty(WM_PC8, COM_CLEAR, 510, 128);
		duty(WM_PC8, COM_SET, 510, 382);
		top_test();
		clock_test();
		final_report();
	end
endmodule
`default_nettype wire
